/* File: tb/dlct_core_model.sv */
`timescale 1ns/1ps
module dlct_core_model (
    input  wire logic       clk,
    input  wire logic [7:0] regRdata,
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regWdata,
    output logic      [3:0] ackVec
);
    // ==========================================================
    // register cycles, launched on falling edges
    initial begin
        regAddr  = 8'h00;
        regWrite = 1'b0;
        regRead  = 1'b0;
        regWdata = 8'h00;
        ackVec   = 4'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr  = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
        regAddr  = ~a;
        regWdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        regAddr = ~a;
        @(negedge clk);
        d = regRdata;
    endtask : rd
    // one-cycle vector acknowledge per source
    task automatic vec(input int i);
        @(negedge clk);
        ackVec[i] = 1'b1;
        @(negedge clk);
        ackVec[i] = 1'b0;
    endtask : vec
endmodule : dlct_core_model

/* File: tb/dual_legacy_counter_timers_bench.sv */
`timescale 1ns/1ps
module dual_legacy_counter_timers_bench;
    logic       clk, rst_b, regWrite, regRead, extClock;
    logic [7:0] regAddr, regWdata, regRdata, rv, rw;
    logic       cnt0, cnt1, pin0_n, pin1_n, t1Pulse;
    logic [3:0] ackVec, irqs;
    logic [3:0] extCnt;
    logic [15:0] v16;
    int         n_fail, total_checks;

    dlct_timers dlct_timers_inst (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .timerZeroCountPin(cnt0), .timerOneCountPin(cnt1), .extIrqZeroPin_n(pin0_n),
        .extIrqOnePin_n(pin1_n), .extClock(extClock), .timerZeroAck(ackVec[0]),
        .timerOneAck(ackVec[1]), .extIrqZeroAck(ackVec[2]), .extIrqOneAck(ackVec[3]),
        .timerZeroIrq(irqs[0]), .timerOneIrq(irqs[1]), .extIrqZeroIrq(irqs[2]),
        .extIrqOneIrq(irqs[3]), .timerOneOverflowPulse(t1Pulse));
    dlct_core_model dlct_core_model_inst (.clk(clk), .regRdata(regRdata),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .ackVec(ackVec));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // external clock, period of eight system clocks
    initial extCnt = 4'h0;
    always @(negedge clk) extCnt <= extCnt + 4'h1;
    assign extClock = extCnt[2];

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chkRng(input logic [15:0] got, input int lo, input int hi);
        total_checks++;
        if ($isunknown(got) || !(got >= lo && got <= hi)) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chkRng
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        dlct_core_model_inst.wr(a, d);
    endtask : wr
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        dlct_core_model_inst.rd(a, rv);
        chk({8'h00, rv}, {8'h00, exp});
    endtask : rdChk
    task automatic rd16(input logic [7:0] lo, input logic [7:0] hi);
        dlct_core_model_inst.rd(lo, rv);
        dlct_core_model_inst.rd(hi, rw);
        v16 = {rw, rv};
    endtask : rd16
    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask : ticks
    // bounded wait on a request line, or on the timer one pulse
    task automatic waitIrq(input int i, input int lim);
        int k;
        k = 0;
        while (((i < 4) ? irqs[i] : t1Pulse) !== 1'b1 && k < lim) begin
            @(negedge clk);
            k++;
        end
        if (k >= lim) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            end_sim();
        end
    endtask : waitIrq
    task automatic loadT0(input logic [7:0] m, input logic [7:0] th, input logic [7:0] tl);
        wr(8'h89, m);
        wr(8'h8C, th);
        wr(8'h8A, tl);
    endtask : loadT0

    // ==========================================================
    // scenarios
    task automatic tRegs;
        for (int i = 0; i < 9; i++) rdChk(8'h87 + i[7:0], 8'h00);
        for (int i = 0; i < 4; i++) wr(8'h8A + i[7:0], 8'h3C + i[7:0]);
        for (int i = 0; i < 4; i++) rdChk(8'h8A + i[7:0], 8'h3C + i[7:0]);
        wr(8'h8E, 8'hFF);
        rdChk(8'h8E, 8'h1B);
    endtask : tRegs
    task automatic tModes;
        logic [7:0] md[3] = '{8'h01, 8'h00, 8'h02};
        logic [7:0] th[3] = '{8'hFF, 8'hFF, 8'h80};
        logic [7:0] tl[3] = '{8'hFE, 8'h1E, 8'hFE};
        wr(8'h8E, 8'h08);
        for (int i = 0; i < 3; i++) begin
            loadT0(md[i], th[i], tl[i]);
            wr(8'h88, 8'h10);
            waitIrq(0, 20);
            wr(8'h88, 8'h20);
            chk({15'h0000, irqs[0]}, 16'h0001);
            if (i < 2) dlct_core_model_inst.vec(0);
            else wr(8'h88, 8'h00);
            chk({15'h0000, irqs[0]}, 16'h0000);
            rd16(8'h8A, 8'h8C);
            chk({8'h00, v16[15:8]}, {8'h00, th[i] + ((i < 2) ? 8'h01 : 8'h00)});
        end
        chkRng({8'h00, v16[7:0]}, 128, 159);
    endtask : tModes
    task automatic tPrescale;
        int dv[4] = '{12, 4, 48, 64};
        for (int i = 0; i < 4; i++) begin
            wr(8'h8E, i[7:0]);
            loadT0(8'h01, 8'h00, 8'h00);
            wr(8'h88, 8'h10);
            ticks(960);
            wr(8'h88, 8'h00);
            rd16(8'h8A, 8'h8C);
            chkRng(v16, 960 / dv[i] - 2, 960 / dv[i] + 2);
        end
    endtask : tPrescale
    task automatic tPins;
        wr(8'h8E, 8'h08);
        loadT0(8'h05, 8'h00, 8'h00);
        wr(8'h88, 8'h10);
        repeat (5) begin
            cnt0 = 1'b0;
            ticks(3);
            cnt0 = 1'b1;
            ticks(3);
        end
        ticks(6);
        wr(8'h88, 8'h00);
        rd16(8'h8A, 8'h8C);
        chk(v16, 16'h0005);
        loadT0(8'h09, 8'h00, 8'h00);
        pin0_n = 1'b0;
        wr(8'h88, 8'h10);
        ticks(20);
        chk({15'h0000, irqs[2]}, 16'h0001);
        dlct_core_model_inst.vec(2);
        chk({15'h0000, irqs[2]}, 16'h0001);
        wr(8'h88, 8'h00);
        rd16(8'h8A, 8'h8C);
        chk(v16, 16'h0000);
        pin0_n = 1'b1;
        wr(8'h88, 8'h10);
        ticks(100);
        wr(8'h88, 8'h01);
        rd16(8'h8A, 8'h8C);
        chkRng(v16, 98, 104);
        chk({15'h0000, irqs[2]}, 16'h0000);
        pin0_n = 1'b0;
        ticks(3);
        pin0_n = 1'b1;
        ticks(6);
        chk({15'h0000, irqs[2]}, 16'h0001);
        dlct_core_model_inst.vec(2);
        chk({15'h0000, irqs[2]}, 16'h0000);
    endtask : tPins
    task automatic tSplit;
        wr(8'h8E, 8'h18);
        wr(8'h8C, 8'hFE);
        wr(8'h8A, 8'h00);
        wr(8'h8B, 8'h1E);
        wr(8'h8D, 8'hFF);
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h03);
        waitIrq(4, 20);
        chk({15'h0000, irqs[1]}, 16'h0000);
        rdChk(8'h8A, 8'h00);
        wr(8'h88, 8'h40);
        waitIrq(1, 20);
        chk({15'h0000, irqs[0]}, 16'h0000);
        wr(8'h89, 8'h33);
        dlct_core_model_inst.rd(8'h8B, rw);
        ticks(10);
        rdChk(8'h8B, rw);
        wr(8'h88, 8'h00);
    endtask : tSplit
    task automatic tOne;
        wr(8'h89, 8'h60);
        wr(8'h8D, 8'hF0);
        wr(8'h8B, 8'hFE);
        wr(8'h88, 8'h40);
        repeat (2) begin
            cnt1 = 1'b0;
            ticks(3);
            cnt1 = 1'b1;
            ticks(3);
        end
        ticks(6);
        chk({15'h0000, irqs[1]}, 16'h0001);
        dlct_core_model_inst.vec(1);
        chk({15'h0000, irqs[1]}, 16'h0000);
        rdChk(8'h8B, 8'hF0);
        wr(8'h88, 8'h04);
        pin1_n = 1'b0;
        ticks(3);
        pin1_n = 1'b1;
        ticks(6);
        chk({15'h0000, irqs[3]}, 16'h0001);
        dlct_core_model_inst.vec(3);
        chk({15'h0000, irqs[3]}, 16'h0000);
    endtask : tOne

    initial begin
        n_fail = 0;
        total_checks = 0;
        rst_b = 1'b0;
        cnt0 = 1'b1;
        cnt1 = 1'b1;
        pin0_n = 1'b1;
        pin1_n = 1'b1;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        tRegs();
        tModes();
        tPrescale();
        tPins();
        tSplit();
        tOne();
        end_sim();
    end
endmodule : dual_legacy_counter_timers_bench

/* File: verilog/dlct_pkg.sv */
package dlct_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_CONTROL   = 8'h88;
    localparam logic [7:0] ADDR_MODE      = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW    = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW    = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH   = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH   = 8'h8D;
    localparam logic [7:0] ADDR_CLK_SEL   = 8'h8E;
    // ==========================================================
    // reset values
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    // ==========================================================
    // control register fields
    localparam int CTL_T1_FLAG  = 7;
    localparam int CTL_T1_RUN   = 6;
    localparam int CTL_T0_FLAG  = 5;
    localparam int CTL_T0_RUN   = 4;
    localparam int CTL_X1_FLAG  = 3;
    localparam int CTL_X1_TYPE  = 2;
    localparam int CTL_X0_FLAG  = 1;
    localparam int CTL_X0_TYPE  = 0;
    // ==========================================================
    // mode register fields
    localparam int MOD_T1_GATE  = 7;
    localparam int MOD_T1_CSEL  = 6;
    localparam int MOD_T1_MODE  = 4;
    localparam int MOD_T0_GATE  = 3;
    localparam int MOD_T0_CSEL  = 2;
    localparam int MOD_T0_MODE  = 0;
    // ==========================================================
    // clock select fields
    localparam int CKS_T1_CHOICE = 4;
    localparam int CKS_T0_CHOICE = 3;
    localparam int CKS_PRESCALE  = 0;
    localparam logic [7:0] CKS_WRITE_MASK = 8'h1B;
    // ==========================================================
    // timer modes
    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } dlct_mode_t;
    // ==========================================================
    // prescale divisors
    localparam logic [5:0] DIV_BY_12  = 6'd12;
    localparam logic [5:0] DIV_BY_4   = 6'd4;
    localparam logic [5:0] DIV_BY_48  = 6'd48;
    localparam logic [5:0] DIV_EXT_8  = 6'd8;
endpackage : dlct_pkg

/* File: verilog/dlct_timers.sv */
`timescale 1ns/1ps
// Contract
// - mode 3 splits timer zero into two independent 8-bit timers
// - split low byte uses timer zero run, select, gate, flag; clock or pin
// - split high byte is a timer on clock or prescale, enabled by timer one run
// - split high byte overflow sets timer one overflow flag
// - in split, timer one never counts pin, never sets flag; overflow pulse kept
// - in split, timer one runs in modes 0-2, halts in mode 3
// - overflow sets flag; software write or vector acknowledge clears it
// - run bits 6 and 4 enable timer one and zero
// - external flag set on chosen edge; level mode follows inverted pin
// - vector acknowledge clears external flag only in edge mode
// - type bit 0 level active low, 1 falling edge; bits 2 and 0
// - gate 1 makes counting need run and high interrupt pin
// - counter select 1 counts falling edges of count pin
// - timer one mode: 13-bit, 16-bit, auto-reload, inactive
// - timer zero mode: 13-bit, 16-bit, auto-reload, split
// - clock choice 0 prescale, 1 system clock; ignored when counter selected
// - prescale 00 /12, 01 /4, 10 /48, 11 external clock /8
// - unused clock select bits read zero, writes ignored
// - each count held in readable writable low and high bytes
// - 13-bit mode uses high byte and low five bits; wrap sets flag
// - 16-bit mode counts all sixteen bits
// - auto-reload overflow sets flag, reloads low from high
module dlct_timers (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    input  wire logic       timerZeroCountPin,
    input  wire logic       timerOneCountPin,
    input  wire logic       extIrqZeroPin_n,
    input  wire logic       extIrqOnePin_n,
    input  wire logic       extClock,
    input  wire logic       timerZeroAck,
    input  wire logic       timerOneAck,
    input  wire logic       extIrqZeroAck,
    input  wire logic       extIrqOneAck,
    output logic            timerZeroIrq,
    output logic            timerOneIrq,
    output logic            extIrqZeroIrq,
    output logic            extIrqOneIrq,
    output logic            timerOneOverflowPulse
);
    // ==========================================================
    // field positions, local copies of the package values
    localparam int CTL_T1_FLAG   = dlct_pkg::CTL_T1_FLAG;
    localparam int CTL_T1_RUN    = dlct_pkg::CTL_T1_RUN;
    localparam int CTL_T0_FLAG   = dlct_pkg::CTL_T0_FLAG;
    localparam int CTL_T0_RUN    = dlct_pkg::CTL_T0_RUN;
    localparam int CTL_X1_FLAG   = dlct_pkg::CTL_X1_FLAG;
    localparam int CTL_X1_TYPE   = dlct_pkg::CTL_X1_TYPE;
    localparam int CTL_X0_FLAG   = dlct_pkg::CTL_X0_FLAG;
    localparam int CTL_X0_TYPE   = dlct_pkg::CTL_X0_TYPE;
    localparam int MOD_T1_GATE   = dlct_pkg::MOD_T1_GATE;
    localparam int MOD_T1_CSEL   = dlct_pkg::MOD_T1_CSEL;
    localparam int MOD_T1_MODE   = dlct_pkg::MOD_T1_MODE;
    localparam int MOD_T0_GATE   = dlct_pkg::MOD_T0_GATE;
    localparam int MOD_T0_CSEL   = dlct_pkg::MOD_T0_CSEL;
    localparam int MOD_T0_MODE   = dlct_pkg::MOD_T0_MODE;
    localparam int CKS_T1_CHOICE = dlct_pkg::CKS_T1_CHOICE;
    localparam int CKS_T0_CHOICE = dlct_pkg::CKS_T0_CHOICE;
    localparam int CKS_PRESCALE  = dlct_pkg::CKS_PRESCALE;
    // ==========================================================
    // registers
    logic [7:0] control_r, control_nxt;
    logic [7:0] mode_r,    mode_nxt;
    logic [7:0] clkSel_r,  clkSel_nxt;
    logic [7:0] t0Low_r,   t0Low_nxt;
    logic [7:0] t0High_r,  t0High_nxt;
    logic [7:0] t1Low_r,   t1Low_nxt;
    logic [7:0] t1High_r,  t1High_nxt;
    logic [7:0] rdata_r,   rdata_nxt;
    logic [5:0] preCnt_r,  preCnt_nxt;
    logic       t1Ovf_r,   t1Ovf_nxt;
    // ==========================================================
    // pin synchronisers: stage a feeds stage b only
    logic [4:0] syncA_r, syncB_r, syncC_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            syncA_r <= 5'h1F;
            syncB_r <= 5'h1F;
            syncC_r <= 5'h1F;
        end else begin
            syncA_r <= {extClock, extIrqOnePin_n, extIrqZeroPin_n,
                        timerOneCountPin, timerZeroCountPin};
            syncB_r <= syncA_r;
            syncC_r <= syncB_r;
        end
    end
    logic [4:0] fallEdge;
    logic       extClkRise;
    assign fallEdge   = syncC_r & ~syncB_r;
    assign extClkRise = syncB_r[4] & ~syncC_r[4];
    // ==========================================================
    // count step helper
    function automatic logic [8:0] inc8(input logic [7:0] v);
        return {1'b0, v} + 9'h001;
    endfunction : inc8
    // ==========================================================
    // prescaler
    logic [5:0] preDiv;
    logic       preTick;
    always_comb begin
        case (clkSel_r[CKS_PRESCALE+:2])
            2'b00:   preDiv = dlct_pkg::DIV_BY_12;
            2'b01:   preDiv = dlct_pkg::DIV_BY_4;
            2'b10:   preDiv = dlct_pkg::DIV_BY_48;
            default: preDiv = dlct_pkg::DIV_EXT_8;
        endcase
        preTick    = 1'b0;
        preCnt_nxt = preCnt_r;
        if (clkSel_r[CKS_PRESCALE+:2] != 2'b11 || extClkRise) begin
            if (preCnt_r >= preDiv - 6'd1) begin
                preCnt_nxt = 6'd0;
                preTick    = 1'b1;
            end else begin
                preCnt_nxt = preCnt_r + 6'd1;
            end
        end
    end
    // ==========================================================
    // timer enables and ticks
    dlct_pkg::dlct_mode_t m0, m1;
    logic split, en0, en1, en0High, tick0, tick1, tickHigh;
    always_comb begin
        m0    = dlct_pkg::dlct_mode_t'(mode_r[MOD_T0_MODE+:2]);
        m1    = dlct_pkg::dlct_mode_t'(mode_r[MOD_T1_MODE+:2]);
        split = (m0 == dlct_pkg::MODE_SPLIT);
        en0   = control_r[CTL_T0_RUN] &&
                (!mode_r[MOD_T0_GATE] || syncB_r[2]);
        en0High = control_r[CTL_T1_RUN];
        if (split) begin
            en1 = (m1 != dlct_pkg::MODE_SPLIT);
        end else begin
            en1 = control_r[CTL_T1_RUN] && (m1 != dlct_pkg::MODE_SPLIT) &&
                  (!mode_r[MOD_T1_GATE] || syncB_r[3]);
        end
        if (mode_r[MOD_T0_CSEL]) begin
            tick0 = fallEdge[0];
        end else begin
            tick0 = clkSel_r[CKS_T0_CHOICE] ? 1'b1 : preTick;
        end
        tickHigh = clkSel_r[CKS_T0_CHOICE] ? 1'b1 : preTick;
        if (mode_r[MOD_T1_CSEL] && !split) begin
            tick1 = fallEdge[1];
        end else begin
            tick1 = clkSel_r[CKS_T1_CHOICE] ? 1'b1 : preTick;
        end
    end
    // ==========================================================
    // counter step for one timer in modes 0-2
    function automatic logic [16:0] stepTimer(input logic [1:0] md,
                                               input logic [7:0] lo,
                                               input logic [7:0] hi);
        logic [8:0] l;
        logic [8:0] h;
        l = inc8(lo);
        h = inc8(hi);
        case (md)
            2'b00: begin
                if (lo[4:0] == 5'h1F) begin
                    return {h[8], h[7:0], lo[7:5], 5'h00};
                end
                return {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
            end
            2'b01: begin
                if (l[8]) begin
                    return {h[8], h[7:0], 8'h00};
                end
                return {1'b0, hi, l[7:0]};
            end
            default: begin
                if (l[8]) begin
                    return {1'b1, hi, hi};
                end
                return {1'b0, hi, l[7:0]};
            end
        endcase
    endfunction : stepTimer
    // ==========================================================
    // counting, flags and register writes
    logic [16:0] s0, s1;
    logic [8:0]  lowInc, highInc;
    logic        ovf0, ovfHigh, ovf1;
    logic        x0Set, x1Set;
    always_comb begin
        s0      = stepTimer(mode_r[MOD_T0_MODE+:2], t0Low_r, t0High_r);
        s1      = stepTimer(mode_r[MOD_T1_MODE+:2], t1Low_r, t1High_r);
        lowInc  = inc8(t0Low_r);
        highInc = inc8(t0High_r);
        t0Low_nxt  = t0Low_r;
        t0High_nxt = t0High_r;
        t1Low_nxt  = t1Low_r;
        t1High_nxt = t1High_r;
        ovf0 = 1'b0;
        ovfHigh = 1'b0;
        ovf1 = 1'b0;
        if (split) begin
            if (en0 && tick0) begin
                t0Low_nxt = lowInc[7:0];
                ovf0      = lowInc[8];
            end
            if (en0High && tickHigh) begin
                t0High_nxt = highInc[7:0];
                ovfHigh    = highInc[8];
            end
        end else if (en0 && tick0) begin
            {ovf0, t0High_nxt, t0Low_nxt} = s0;
        end
        if (en1 && tick1) begin
            {ovf1, t1High_nxt, t1Low_nxt} = s1;
        end
        t1Ovf_nxt = ovf1;
        control_nxt = control_r;
        mode_nxt    = mode_r;
        clkSel_nxt  = clkSel_r;
        if (regWrite) begin
            if (regAddr == dlct_pkg::ADDR_CONTROL) begin
                control_nxt = regWdata;
            end else if (regAddr == dlct_pkg::ADDR_MODE) begin
                mode_nxt = regWdata;
            end else if (regAddr == dlct_pkg::ADDR_CLK_SEL) begin
                clkSel_nxt = regWdata & dlct_pkg::CKS_WRITE_MASK;
            end else if (regAddr == dlct_pkg::ADDR_T0_LOW) begin
                t0Low_nxt = regWdata;
            end else if (regAddr == dlct_pkg::ADDR_T0_HIGH) begin
                t0High_nxt = regWdata;
            end else if (regAddr == dlct_pkg::ADDR_T1_LOW) begin
                t1Low_nxt = regWdata;
            end else if (regAddr == dlct_pkg::ADDR_T1_HIGH) begin
                t1High_nxt = regWdata;
            end
        end
        // clears by acknowledge, then sets win
        if (timerZeroAck) control_nxt[CTL_T0_FLAG] = 1'b0;
        if (timerOneAck)  control_nxt[CTL_T1_FLAG] = 1'b0;
        if (extIrqZeroAck && control_r[CTL_X0_TYPE]) control_nxt[CTL_X0_FLAG] = 1'b0;
        if (extIrqOneAck && control_r[CTL_X1_TYPE])  control_nxt[CTL_X1_FLAG] = 1'b0;
        if (ovf0) control_nxt[CTL_T0_FLAG] = 1'b1;
        if (split ? ovfHigh : ovf1) control_nxt[CTL_T1_FLAG] = 1'b1;
        x0Set = control_r[CTL_X0_TYPE] ? fallEdge[2] : 1'b0;
        x1Set = control_r[CTL_X1_TYPE] ? fallEdge[3] : 1'b0;
        if (x0Set) control_nxt[CTL_X0_FLAG] = 1'b1;
        if (x1Set) control_nxt[CTL_X1_FLAG] = 1'b1;
        if (!control_nxt[CTL_X0_TYPE]) control_nxt[CTL_X0_FLAG] = ~syncB_r[2];
        if (!control_nxt[CTL_X1_TYPE]) control_nxt[CTL_X1_FLAG] = ~syncB_r[3];
        rdata_nxt = rdata_r;
        if (regRead) begin
            if (regAddr == dlct_pkg::ADDR_CONTROL) begin
                rdata_nxt = control_r;
            end else if (regAddr == dlct_pkg::ADDR_MODE) begin
                rdata_nxt = mode_r;
            end else if (regAddr == dlct_pkg::ADDR_CLK_SEL) begin
                rdata_nxt = clkSel_r;
            end else if (regAddr == dlct_pkg::ADDR_T0_LOW) begin
                rdata_nxt = t0Low_r;
            end else if (regAddr == dlct_pkg::ADDR_T0_HIGH) begin
                rdata_nxt = t0High_r;
            end else if (regAddr == dlct_pkg::ADDR_T1_LOW) begin
                rdata_nxt = t1Low_r;
            end else if (regAddr == dlct_pkg::ADDR_T1_HIGH) begin
                rdata_nxt = t1High_r;
            end else begin
                rdata_nxt = dlct_pkg::RESET_BYTE;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            control_r <= dlct_pkg::RESET_BYTE;
            mode_r    <= dlct_pkg::RESET_BYTE;
            clkSel_r  <= dlct_pkg::RESET_BYTE;
            t0Low_r   <= dlct_pkg::RESET_BYTE;
            t0High_r  <= dlct_pkg::RESET_BYTE;
            t1Low_r   <= dlct_pkg::RESET_BYTE;
            t1High_r  <= dlct_pkg::RESET_BYTE;
            rdata_r   <= dlct_pkg::RESET_BYTE;
            preCnt_r  <= 6'd0;
            t1Ovf_r   <= 1'b0;
        end else begin
            control_r <= control_nxt;
            mode_r    <= mode_nxt;
            clkSel_r  <= clkSel_nxt;
            t0Low_r   <= t0Low_nxt;
            t0High_r  <= t0High_nxt;
            t1Low_r   <= t1Low_nxt;
            t1High_r  <= t1High_nxt;
            rdata_r   <= rdata_nxt;
            preCnt_r  <= preCnt_nxt;
            t1Ovf_r   <= t1Ovf_nxt;
        end
    end
    assign regRdata              = rdata_r;
    assign timerZeroIrq          = control_r[CTL_T0_FLAG];
    assign timerOneIrq           = control_r[CTL_T1_FLAG];
    assign extIrqZeroIrq         = control_r[CTL_X0_FLAG];
    assign extIrqOneIrq          = control_r[CTL_X1_FLAG];
    assign timerOneOverflowPulse = t1Ovf_r;
    // ==========================================================
    // checks
    a_reload_keeps_high: assert property (@(posedge clk) disable iff (!rst_b)
        (!split && m0 == dlct_pkg::MODE_RELOAD && en0 && tick0 && t0Low_r == 8'hFF && !regWrite)
        |=> (t0Low_r == $past(t0High_r) && control_r[CTL_T0_FLAG]))
        else $error("reload failed");
    a_split_high_flag: assert property (@(posedge clk) disable iff (!rst_b)
        (split && en0High && tickHigh && t0High_r == 8'hFF) |=> timerOneIrq)
        else $error("split high overflow lost");
    a_run_off_holds: assert property (@(posedge clk) disable iff (!rst_b)
        (!control_r[CTL_T0_RUN] && !regWrite) |=> $stable(t0Low_r))
        else $error("timer zero moved while stopped");
    a_gate_blocks: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_r[MOD_T0_GATE] && !syncB_r[2] && !regWrite) |=> $stable(t0Low_r))
        else $error("gate ignored");
    a_level_follows: assert property (@(posedge clk) disable iff (!rst_b)
        (!control_r[CTL_X0_TYPE] && !regWrite) |=> extIrqZeroIrq == ~$past(syncB_r[2]))
        else $error("level flag wrong");
    a_split_no_t1flag: assert property (@(posedge clk) disable iff (!rst_b)
        (split && !ovfHigh && !regWrite && !timerOneIrq) |=> !timerOneIrq)
        else $error("timer one flag set in split");
    a_timer_clock_select_unused: assert property (@(posedge clk) disable iff (!rst_b)
        (clkSel_r & ~dlct_pkg::CKS_WRITE_MASK) == 8'h00)
        else $error("unused clock select bit set");
    a_mode3_halt: assert property (@(posedge clk) disable iff (!rst_b)
        (m1 == dlct_pkg::MODE_SPLIT && !regWrite) |=> $stable(t1Low_r) && $stable(t1High_r))
        else $error("timer one ran in mode 3");
endmodule : dlct_timers
